// ==== rtl/ivp_pick_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ivp_pick_if;
  logic [ivp_pkg::NVEC-1:0] req;
  logic any;
  logic [ivp_pkg::VEC_W-1:0] num;
  modport enc (input req, output any, output num);
  modport ctl (output req, input any, input num);
endinterface
`default_nettype wire

// ==== rtl/ivp_pkg.sv ====
package ivp_pkg;
  localparam int NVEC = 64;
  localparam int VEC_W = 6;
  localparam int NSRC = 40;
  localparam int NCAUSE = 8;
  localparam logic [5:0] VEC_RESET = 6'h00;
  localparam logic [5:0] VEC_SWI = 6'h01;
  localparam logic [5:0] VEC_PORT = 6'h16;
  localparam logic [5:0] VEC_LOW_MAX = 6'h1F;
  localparam logic [5:0] VEC_HIGH_MIN = 6'h30;
  localparam logic [5:0] VEC_HIGH_MAX = 6'h37;
  localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
  localparam int MASKABLE_MIN = 2;
  localparam int CCR_I_BIT = 3;
  localparam logic [2:0] PUSH_PCL = 3'h0;
  localparam logic [2:0] PUSH_PCH = 3'h1;
  localparam logic [2:0] PUSH_X = 3'h2;
  localparam logic [2:0] PUSH_A = 3'h3;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  // source index to vector: 0..29 -> 2..31, 30..37 -> 48..55,
  // 38 and 39 are port B and port D, sharing the port vector with index 20
  localparam int SRC_PORT_A = 20;
  localparam int SRC_PORT_B = 38;
  localparam int SRC_PORT_D = 39;
  localparam int SRC_LOW_CNT = 30;
  localparam int SRC_HIGH_END = 38;
  localparam int SRC_LOW_BASE = 2;
  localparam int SRC_HIGH_BASE = 18;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PUSH = 6'h02,
    ST_FETCH_HI = 6'h04,
    ST_FETCH_LO = 6'h08,
    ST_CAP_HI = 6'h10,
    ST_CAP_LO = 6'h20
  } ivp_state_type;

  function automatic logic [5:0] src_vec(input int i);
    if (i < SRC_LOW_CNT) begin
      return 6'(i + SRC_LOW_BASE);
    end else if (i < SRC_HIGH_END) begin
      return 6'(i + SRC_HIGH_BASE);
    end
    return VEC_PORT;
  endfunction

  function automatic logic vec_usable(input logic [5:0] v);
    return (v <= VEC_LOW_MAX) || (v >= VEC_HIGH_MIN && v <= VEC_HIGH_MAX);
  endfunction

  function automatic logic [15:0] vec_addr(input logic [5:0] v);
    return VEC_TOP_ADDR - {9'h000, v, 1'b0};
  endfunction
endpackage

// ==== rtl/ivp_prio_pick.sv ====
`timescale 1ns/1ps
`default_nettype none
module ivp_prio_pick (
  ivp_pick_if.enc pk
);
  // walk downward so the smallest usable vector number wins
  always_comb begin
    pk.any = 1'b0;
    pk.num = ivp_pkg::VEC_RESET;
    for (int v = ivp_pkg::NVEC - 1; v >= 0; v--) begin
      if (pk.req[v] && ivp_pkg::vec_usable(6'(v))) begin
        pk.any = 1'b1;
        pk.num = 6'(v);
      end
    end
  end
endmodule // ivp_prio_pick
`default_nettype wire

// ==== rtl/ivp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ivp_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [ivp_pkg::NSRC-1:0] SRC_EVENT,
  input wire logic [ivp_pkg::NSRC-1:0] SRC_CLEAR,
  input wire logic [ivp_pkg::NSRC-1:0] SRC_ENABLE,
  input wire logic [ivp_pkg::NCAUSE-1:0] RESET_CAUSE,
  input wire logic SWI_REQ,
  input wire logic MASK_SET,
  input wire logic MASK_CLEAR,
  input wire logic INSTR_DONE,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] X_IN,
  input wire logic [7:0] ACC_IN,
  input wire logic [7:0] CCR_IN,
  input wire logic [15:0] SP_IN,
  input wire logic [7:0] BUS_RDATA,
  output logic [ivp_pkg::NSRC-1:0] SRC_FLAG,
  output logic I_MASK,
  output logic IRQ_PENDING,
  output logic SEQ_BUSY,
  output logic [15:0] BUS_ADDR,
  output logic [7:0] BUS_WDATA,
  output logic BUS_WR,
  output logic BUS_RD,
  output logic [15:0] NEW_PC,
  output logic PC_LOAD,
  output logic [15:0] SP_OUT,
  output logic SP_LOAD
);
  ivp_pkg::ivp_state_type state_reg, state_next;
  logic [2:0] push_cnt_reg, push_cnt_next;
  logic [15:0] sp_reg, sp_next;
  logic [5:0] vec_reg, vec_next;
  logic [7:0] hi_reg, hi_next;
  logic i_mask_reg, i_mask_next;
  logic reset_pend_reg, reset_pend_next;
  logic swi_pend_reg, swi_pend_next;
  logic [ivp_pkg::NSRC-1:0] flag_reg, flag_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [15:0] new_pc_reg, new_pc_next;
  logic pc_load_reg, pc_load_next;
  logic sp_load_reg, sp_load_next;
  logic [ivp_pkg::NVEC-1:0] vec_req;
  logic mask_any;
  logic [7:0] ccr_stk;

  ivp_pick_if pick();
  ivp_prio_pick u_pick (
    .pk(pick.enc)
  );

  always_comb begin
    vec_req = '0;
    for (int i = 0; i < ivp_pkg::NSRC; i++) begin
      if (flag_reg[i] && SRC_ENABLE[i]) begin
        vec_req[ivp_pkg::src_vec(i)] = 1'b1;
      end
    end
    vec_req[ivp_pkg::VEC_RESET] = reset_pend_reg;
    vec_req[ivp_pkg::VEC_SWI] = swi_pend_reg;
  end
  assign pick.req = vec_req;
  assign mask_any = |vec_req[ivp_pkg::NVEC-1:ivp_pkg::MASKABLE_MIN];

  always_comb begin
    ccr_stk = CCR_IN;
    ccr_stk[ivp_pkg::CCR_I_BIT] = i_mask_reg;
  end

  always_comb begin
    state_next = state_reg;
    push_cnt_next = push_cnt_reg;
    sp_next = sp_reg;
    vec_next = vec_reg;
    hi_next = hi_reg;
    reset_pend_next = reset_pend_reg | (|RESET_CAUSE);
    swi_pend_next = swi_pend_reg | SWI_REQ;
    // a flag event in the clear cycle still lands
    flag_next = (flag_reg & ~SRC_CLEAR) | SRC_EVENT;
    i_mask_next = (i_mask_reg & ~MASK_CLEAR) | MASK_SET;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    new_pc_next = new_pc_reg;
    pc_load_next = 1'b0;
    sp_load_next = 1'b0;
    case (state_reg)
      ivp_pkg::ST_IDLE: begin
        if (reset_pend_reg) begin
          // reset causes do not wait for the instruction nor stack
          i_mask_next = 1'b1;
          vec_next = pick.num;
          state_next = ivp_pkg::ST_FETCH_HI;
        end else if (INSTR_DONE &&
                     (swi_pend_reg || (mask_any && !i_mask_reg))) begin
          sp_next = SP_IN;
          push_cnt_next = ivp_pkg::PUSH_PCL;
          state_next = ivp_pkg::ST_PUSH;
        end
      end
      ivp_pkg::ST_PUSH: begin
        wr_next = 1'b1;
        addr_next = sp_reg;
        case (push_cnt_reg)
          ivp_pkg::PUSH_PCL: wdata_next = PC_IN[7:0];
          ivp_pkg::PUSH_PCH: wdata_next = PC_IN[15:8];
          ivp_pkg::PUSH_X: wdata_next = X_IN;
          ivp_pkg::PUSH_A: wdata_next = ACC_IN;
          default: wdata_next = ccr_stk;
        endcase
        sp_next = sp_reg - 16'h0001;
        push_cnt_next = push_cnt_reg + 3'h1;
        if (push_cnt_reg == ivp_pkg::PUSH_LAST) begin
          i_mask_next = 1'b1;
          vec_next = pick.num;
          sp_load_next = 1'b1;
          state_next = ivp_pkg::ST_FETCH_HI;
        end
      end
      ivp_pkg::ST_FETCH_HI: begin
        rd_next = 1'b1;
        addr_next = ivp_pkg::vec_addr(vec_reg);
        state_next = ivp_pkg::ST_FETCH_LO;
      end
      ivp_pkg::ST_FETCH_LO: begin
        rd_next = 1'b1;
        addr_next = ivp_pkg::vec_addr(vec_reg) + 16'h0001;
        state_next = ivp_pkg::ST_CAP_HI;
      end
      ivp_pkg::ST_CAP_HI: begin
        hi_next = BUS_RDATA;
        state_next = ivp_pkg::ST_CAP_LO;
      end
      ivp_pkg::ST_CAP_LO: begin
        new_pc_next = {hi_reg, BUS_RDATA};
        pc_load_next = 1'b1;
        if (vec_reg == ivp_pkg::VEC_RESET) begin
          reset_pend_next = |RESET_CAUSE;
        end
        if (vec_reg == ivp_pkg::VEC_SWI) begin
          swi_pend_next = SWI_REQ;
        end
        state_next = ivp_pkg::ST_IDLE;
      end
      default: state_next = ivp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // come out of reset straight into the reset vector fetch
      state_reg <= ivp_pkg::ST_FETCH_HI;
      push_cnt_reg <= ivp_pkg::PUSH_PCL;
      sp_reg <= 16'h0000;
      vec_reg <= ivp_pkg::VEC_RESET;
      hi_reg <= 8'h00;
      i_mask_reg <= 1'b1;
      reset_pend_reg <= 1'b1;
      swi_pend_reg <= 1'b0;
      flag_reg <= '0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      new_pc_reg <= 16'h0000;
      pc_load_reg <= 1'b0;
      sp_load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      push_cnt_reg <= push_cnt_next;
      sp_reg <= sp_next;
      vec_reg <= vec_next;
      hi_reg <= hi_next;
      i_mask_reg <= i_mask_next;
      reset_pend_reg <= reset_pend_next;
      swi_pend_reg <= swi_pend_next;
      flag_reg <= flag_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      new_pc_reg <= new_pc_next;
      pc_load_reg <= pc_load_next;
      sp_load_reg <= sp_load_next;
    end
  end

  assign SRC_FLAG = flag_reg;
  assign I_MASK = i_mask_reg;
  assign IRQ_PENDING = mask_any && !i_mask_reg;
  assign SEQ_BUSY = (state_reg != ivp_pkg::ST_IDLE);
  assign BUS_ADDR = addr_reg;
  assign BUS_WDATA = wdata_reg;
  assign BUS_WR = wr_reg;
  assign BUS_RD = rd_reg;
  assign NEW_PC = new_pc_reg;
  assign PC_LOAD = pc_load_reg;
  assign SP_OUT = sp_reg;
  assign SP_LOAD = sp_load_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_vec_reads;
    BUS_RD && BUS_ADDR == ivp_pkg::vec_addr(vec_reg) ##1
    BUS_RD && BUS_ADDR == ivp_pkg::vec_addr(vec_reg) + 16'h0001;
  endsequence

  sequence s_capture;
    state_reg == ivp_pkg::ST_CAP_HI ##1 state_reg == ivp_pkg::ST_CAP_LO;
  endsequence

  chk_vec_byte_order: assert property (
    state_reg == ivp_pkg::ST_FETCH_HI |=> s_vec_reads)
    else $error("vector bytes not read high then low");

  chk_jump_target: assert property (
    s_capture |=> PC_LOAD && NEW_PC == {$past(BUS_RDATA, 2), $past(BUS_RDATA)})
    else $error("new pc not assembled from vector bytes");

  chk_push_first: assert property (
    state_reg == ivp_pkg::ST_PUSH && push_cnt_reg == ivp_pkg::PUSH_PCL
    |=> BUS_WR && BUS_WDATA == $past(PC_IN[7:0]) ##1
        BUS_WR && BUS_WDATA == $past(PC_IN[15:8]))
    else $error("stack push order wrong");

  chk_mask_on_stack: assert property (
    state_reg == ivp_pkg::ST_PUSH && push_cnt_reg == ivp_pkg::PUSH_LAST
    |=> I_MASK && vec_reg == $past(pick.num)
        && state_reg == ivp_pkg::ST_FETCH_HI)
    else $error("mask or vector not set after stacking");

  chk_reset_masked: assert property (
    state_reg == ivp_pkg::ST_FETCH_HI && vec_reg == ivp_pkg::VEC_RESET
    |-> I_MASK ##1 BUS_ADDR == ivp_pkg::VEC_TOP_ADDR)
    else $error("reset vector fetched unmasked or misplaced");

  chk_flag_sets: assert property (
    |SRC_EVENT |=> (SRC_FLAG & $past(SRC_EVENT)) == $past(SRC_EVENT))
    else $error("source event did not set its flag");

  chk_accept_gate: assert property (
    state_reg == ivp_pkg::ST_IDLE && state_next == ivp_pkg::ST_PUSH
    |-> INSTR_DONE && (swi_pend_reg || (mask_any && !i_mask_reg)))
    else $error("request accepted while masked or mid instruction");

  chk_prio_pick: assert property (
    pick.any |-> vec_req[pick.num] && ivp_pkg::vec_usable(pick.num)
    && ((vec_req & ((64'h1 << pick.num) - 64'h1)) == 64'h0))
    else $error("lower vector number pending but not chosen");

  chk_port_share: assert property (
    vec_req[ivp_pkg::VEC_PORT] ==
    ((flag_reg[ivp_pkg::SRC_PORT_A] && SRC_ENABLE[ivp_pkg::SRC_PORT_A]) ||
     (flag_reg[ivp_pkg::SRC_PORT_B] && SRC_ENABLE[ivp_pkg::SRC_PORT_B]) ||
     (flag_reg[ivp_pkg::SRC_PORT_D] && SRC_ENABLE[ivp_pkg::SRC_PORT_D])))
    else $error("shared port vector request mismatch");
endmodule // ivp_top
`default_nettype wire

// ==== sim/ivp_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ivp_top_bench;
  logic clk = 0, rst_n = 0, swi = 0, mset = 0, mclr = 0, done = 0;
  logic [39:0] ev = '0, clr = '0, en = '0, mflag, flag;
  logic [7:0] cause = '0, x = 0, acc = 0, condition_code_reg = 0, rdata, wdata;
  logic [15:0] pc = 0, sp = 16'h0100, addr, npc, spo, splast;
  logic imask, pend, busy, wr, rd, pc_low_byte, spl;
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 75, best;
  logic [23:0] wq[$];
  logic [15:0] rq[$];

  always #5 clk = ~clk;

  ivp_top ivp_top_i (.SYS_CLK(clk), .RST_N(rst_n), .SRC_EVENT(ev),
    .SRC_CLEAR(clr), .SRC_ENABLE(en), .RESET_CAUSE(cause), .SWI_REQ(swi),
    .MASK_SET(mset), .MASK_CLEAR(mclr), .INSTR_DONE(done), .PC_IN(pc),
    .X_IN(x), .ACC_IN(acc), .CCR_IN(condition_code_reg), .SP_IN(sp), .BUS_RDATA(rdata),
    .SRC_FLAG(flag), .I_MASK(imask), .IRQ_PENDING(pend), .SEQ_BUSY(busy),
    .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd),
    .NEW_PC(npc), .PC_LOAD(pc_low_byte), .SP_OUT(spo), .SP_LOAD(spl));
  ivp_vec_mem ivp_vec_mem_i (.clk(clk), .rd(rd), .addr(addr), .rdata(rdata));

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (rst_n) begin
      chk("flags", {24'h0, mflag}, {24'h0, flag});
      if (wr) wq.push_back({addr, wdata});
      if (rd) rq.push_back(addr);
      if (spl) splast = spo;
    end
    mflag = rst_n ? (mflag | ev) & ~(clr & ~ev) : '0;
    if (cyc == 10000) begin
      n_fail++;
      final_report();
    end
  end

  function automatic int svec(input int i);
    return i < 30 ? i + 2 : (i < 38 ? i + 18 : 22);
  endfunction

  // lowest enabled vector wins; 99 means nothing is asking
  function automatic int win();
    win = 99;
    for (int i = 0; i < 40; i++)
      if (mflag[i] && en[i] && svec(i) < win) win = svec(i);
  endfunction

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rnd();
    pc = 16'($random(seed));
    x = 8'($random(seed));
    acc = 8'($random(seed));
    condition_code_reg = 8'($random(seed));
    sp = 16'($random(seed)) | 16'h0010;
  endtask

  task automatic seq(input int vec, input bit stk, input bit mb);
    logic [15:0] va;
    logic [7:0] d [5];
    int k;
    va = 16'hFFFE - 16'(2 * vec);
    d = '{pc[7:0], pc[15:8], x, acc, {condition_code_reg[7:4], mb, condition_code_reg[2:0]}};
    k = 0;
    while (pc_low_byte !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    chk("rd_cnt", 2, rq.size());
    chk("rd_addr", {va, va + 16'h1}, {rq[0], rq[1]});
    chk("new_pc", {va[7:0] ^ 8'h5A, (va[7:0] | 8'h01) ^ 8'h5A}, npc);
    chk("mask", 1, imask);
    chk("wr_cnt", stk ? 5 : 0, wq.size());
    if (stk) begin
      for (int j = 0; j < 5; j++)
        chk("push", {sp - 16'(j), d[j]}, wq[j]);
      chk("sp", sp - 16'h5, splast);
    end
    wq.delete();
    rq.delete();
  endtask

  initial begin
    tick(8);
    rst_n = 1;
    chk("mask_rst", 1, imask);
    seq(0, 0, 1);
    mset = 1;
    mclr = 1;
    tick();
    mset = 0;
    mclr = 0;
    tick();
    chk("set_wins", 1, imask);
    done = 1;
    for (int c = 0; c < 8; c++) begin
      cause = 8'(1 << c);
      tick();
      cause = 0;
      seq(0, 0, 1);
    end
    rnd();
    swi = 1;
    tick();
    swi = 0;
    seq(1, 1, 1);
    // singles sweep every source, then random mixes leave leftovers pending
    for (int k = 0; k < 70; k++) begin
      rnd();
      ev = (k < 40) ? 40'h1 << k : {8'($random(seed)), 32'($random(seed))}
        & {8'($random(seed)), 32'($random(seed))};
      en = {8'($random(seed)), 32'($random(seed))};
      if (k < 40) en[k] = 1'b1;
      done = 1;
      tick();
      ev = '0;
      tick(2);
      chk("masked", 0, busy);
      done = 0;
      mclr = 1;
      tick();
      mclr = 0;
      tick(2);
      best = win();
      chk("pend", best < 99, pend);
      chk("mid_instr", 0, busy);
      done = 1;
      if (best == 99) begin
        tick(8);
        chk("idle", 0, busy);
        mset = 1;
        tick();
        mset = 0;
      end else begin
        tick();
        chk("start", 1, busy);
        if (k >= 40 && k[0]) begin
          ev[0] = 1'b1;
          en[0] = 1'b1;
          tick();
          ev = '0;
          best = win();
        end
        seq(best, 1, 0);
        for (int i = 0; i < 40; i++)
          clr[i] = (svec(i) == best);
        tick();
        clr = '0;
      end
    end
    // mid-run reset with the mask cleared must bring the mask back up
    done = 0;
    mclr = 1;
    tick();
    mclr = 0;
    chk("mask_clr", 0, imask);
    rst_n = 0;
    tick(2);
    chk("mask_mid", 1, imask);
    rst_n = 1;
    seq(0, 0, 1);
    final_report();
  end
endmodule // ivp_top_bench
`default_nettype wire

// ==== sim/ivp_vec_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module ivp_vec_mem (
  input wire logic clk,
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [7:0] rdata
);
  initial rdata = 8'h00;
  // idle bus flips each cycle so a late sample never matches by luck
  always @(posedge clk) begin
    if (rd) begin
      rdata <= addr[7:0] ^ 8'h5A;
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule // ivp_vec_mem
`default_nettype wire
